// >>> design/tpb_params.svh
/*
 * Constants of the timer, PWM and buzzer unit: register offsets,
 * field positions, reset values and fixed counter values.
 * Assumes it is included by bare name from design files only.
 */
`ifndef TPB_PARAMS_SVH
`define TPB_PARAMS_SVH

// Register offsets on the 4-bit register port
`define TPB_ADDR_COUNT_LOW 4'h0
`define TPB_ADDR_CTRL_ONE 4'h1
`define TPB_ADDR_CTRL_TWO 4'h2
`define TPB_ADDR_DUTY_LOW 4'h3
`define TPB_ADDR_PS_VALUE 4'h4
`define TPB_ADDR_BUZZER 4'h5
`define TPB_ADDR_HIGH_BITS 4'h8
`define TPB_ADDR_HOSC_SEL 4'h9
`define TPB_ADDR_IRQ_STATUS 4'hA
`define TPB_ADDR_IRQ_MASK 4'hB

// Fields of timer_control_one
`define TPB_C1_ENABLE 0
`define TPB_C1_RELOAD_SEL 1
`define TPB_C1_ONE_SHOT 2
`define TPB_C1_MATCH_OE 5
`define TPB_C1_PWM_AL 6
`define TPB_C1_PWM_OE 7
`define TPB_C1_RW_MASK 8'hE7

// Fields of timer_control_two
`define TPB_C2_PS_SEL_HI 2
`define TPB_C2_PS_DIS_N 3
`define TPB_C2_EDGE_SEL 4
`define TPB_C2_CLK_SRC 5
`define TPB_C2_RW_MASK 8'h3F

// Fields of buzzer_control
`define TPB_BZ_SEL_HI 3
`define TPB_BZ_SRC_TIMER 3
`define TPB_BZ_ENABLE 7
`define TPB_BZ_TAP_HI 2
`define TPB_BZ_RW_MASK 8'h8F

// Fields of timer_high_bits
`define TPB_HB_DUTY_LO 0
`define TPB_HB_DUTY_HI 1
`define TPB_HB_RELOAD_LO 4
`define TPB_HB_RELOAD_HI 5
`define TPB_HB_RW_MASK 8'h33

// Field of the high-oscillator select register
`define TPB_HOSC_SEL_BIT 0

// Interrupt status bits
`define TPB_IRQ_UNDERFLOW 0
`define TPB_IRQ_ONE_SHOT_DONE 1
`define TPB_IRQ_BITS 2

// Reset values
`define TPB_RST_CTRL_ONE 8'h00
`define TPB_RST_CTRL_TWO 8'h3F
`define TPB_RST_BUZZER 8'h0F
`define TPB_RST_PS_VALUE 8'hFF
`define TPB_RST_BYTE 8'h00

// Counter constants
`define TPB_COUNT_ZERO 10'h000
`define TPB_COUNT_ONE 10'h001
`define TPB_COUNT_ALL_ONES 10'h3FF

`endif

// >>> design/tpb_pkg.sv
/*
 * Types shared by the timer, PWM and buzzer unit.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package tpb_pkg;

   // Width of the timer count
   typedef logic [9:0] tpb_count_t;

   // Timer clock source, one-hot
   typedef enum logic [2:0] {
      TPB_SRC_INSTR = 3'b001,
      TPB_SRC_HOSC = 3'b010,
      TPB_SRC_EXT = 3'b100
   } tpb_src_e;

endpackage

// >>> design/tpb_unit.sv
/*
 * Timer with prescaler, PWM, underflow toggle output and buzzer,
 * programmed through a byte-wide register port.
 * Assumes one 100 MHz clock; the instruction clock and the high
 * oscillator arrive as one-cycle enables on that clock, the external
 * clock arrives as a raw pin and is synchronised here.
 * Register writes and reads come from a master on the same clock that
 * never waits; read data stand for one cycle only.
 */
// The plain strobed port was decided locally.
// Overview of operation
// - Enabled timer decrements once per selected tick.
// - Non-stop, no reload: wrap to all ones.
// - Non-stop with reload: copy reload value.
// - One-shot counts to zero, then stops.
// - Polarity bit makes PWM active low.
// - PWM drives pins only when enabled.
// - Underflow toggles match output, gated to pin.
// - Prescaler divides by two to sel plus one.
// - Edge bit picks falling or rising external edge.
// - Clock-source bit selects external pin clock.
// - Reload sets frame, ten-bit duty sets width.
// - Prescaler value register reads live counter.
// - Buzzer taps prescaler or timer bit.
// - Count write loads count and reload together.
// - High-oscillator select overrides clock source bit.
`timescale 1ns/100ps
`default_nettype none
`include "tpb_params.svh"

module tpb_unit
   import tpb_pkg::*;
#(
   parameter int COUNT_WIDTH = 10,
   parameter int PS_WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_instr_tick,
   input wire logic i_hosc_tick,
   input wire logic i_external_clock_pin,
   output logic [7:0] o_rdata,
   output logic o_pwm_level,
   output logic o_pwm_output_enable,
   output logic o_underflow_toggle_out,
   output logic o_match_output_enable,
   output logic o_buzzer,
   output logic o_irq
);

   // The logic is written for the documented widths only
   if (COUNT_WIDTH != 10 || PS_WIDTH != 8) begin : g_width_check
      $error("tpb_unit supports COUNT_WIDTH 10 and PS_WIDTH 8 only");
   end

   // Software registers
   logic [7:0] ctrl_one_q; // timer_control_one
   logic [7:0] ctrl_two_q; // timer_control_two
   logic [7:0] duty_low_q; // pwm_duty_low
   logic [7:0] buzzer_ctrl_q; // buzzer_control
   logic [7:0] high_bits_q; // timer_high_bits
   logic hosc_sel_q; // high_osc_clock_select
   logic [`TPB_IRQ_BITS-1:0] irq_status_q; // Sticky events
   logic [`TPB_IRQ_BITS-1:0] irq_mask_q; // Interrupt gates

   // Counters
   tpb_count_t count_q; // Timer count
   tpb_count_t reload_q; // Reload register
   logic [7:0] ps_count_q; // Prescaler counter
   logic toggle_q; // Underflow toggle

   // External clock synchroniser and edge history
   logic ext_meta_q; // First stage, read only by the second
   logic ext_sync_q; // Second stage
   logic ext_prev_q; // Previous synchronised level

   // Decoded write strobes
   logic wr_count, wr_ctrl_one, wr_ctrl_two, wr_duty, wr_buzzer;
   logic wr_high, wr_hosc, wr_status, wr_mask;

   // Control fields
   logic timer_enable, reload_select, one_shot_select;
   logic pwm_active_low, pwm_output_enable, match_output_enable;
   logic clock_source_select, external_edge_select, prescaler_disable_n;
   logic [2:0] prescaler_rate_select;
   logic buzzer_enable;
   logic [3:0] buzzer_frequency_select;

   // Datapath nets
   tpb_src_e src_sel; // Selected clock source
   logic ext_edge; // Chosen external edge seen
   logic src_tick; // Tick before the prescaler
   logic [7:0] ps_mask; // Low bits that must be zero for a tick
   logic timer_tick; // Tick that steps the timer
   logic underflow; // Non-stop underflow event
   logic one_shot_done; // One-shot reached zero
   tpb_count_t duty_value; // Ten-bit duty
   tpb_count_t write_value; // Value loaded by a count write
   logic [`TPB_IRQ_BITS-1:0] irq_events; // This cycle's events
   logic [7:0] rdata_d; // Read mux result

   // Field extraction
   assign timer_enable = ctrl_one_q[`TPB_C1_ENABLE];
   assign reload_select = ctrl_one_q[`TPB_C1_RELOAD_SEL];
   assign one_shot_select = ctrl_one_q[`TPB_C1_ONE_SHOT];
   assign pwm_active_low = ctrl_one_q[`TPB_C1_PWM_AL];
   assign pwm_output_enable = ctrl_one_q[`TPB_C1_PWM_OE];
   assign match_output_enable = ctrl_one_q[`TPB_C1_MATCH_OE];
   assign clock_source_select = ctrl_two_q[`TPB_C2_CLK_SRC];
   assign external_edge_select = ctrl_two_q[`TPB_C2_EDGE_SEL];
   assign prescaler_disable_n = ctrl_two_q[`TPB_C2_PS_DIS_N];
   assign prescaler_rate_select = ctrl_two_q[`TPB_C2_PS_SEL_HI:0];
   assign buzzer_enable = buzzer_ctrl_q[`TPB_BZ_ENABLE];
   assign buzzer_frequency_select = buzzer_ctrl_q[`TPB_BZ_SEL_HI:0];

   // Address decode, writes to read-only offsets fall away
   assign wr_count = i_wr && (i_addr == `TPB_ADDR_COUNT_LOW);
   assign wr_ctrl_one = i_wr && (i_addr == `TPB_ADDR_CTRL_ONE);
   assign wr_ctrl_two = i_wr && (i_addr == `TPB_ADDR_CTRL_TWO);
   assign wr_duty = i_wr && (i_addr == `TPB_ADDR_DUTY_LOW);
   assign wr_buzzer = i_wr && (i_addr == `TPB_ADDR_BUZZER);
   assign wr_high = i_wr && (i_addr == `TPB_ADDR_HIGH_BITS);
   assign wr_hosc = i_wr && (i_addr == `TPB_ADDR_HOSC_SEL);
   assign wr_status = i_wr && (i_addr == `TPB_ADDR_IRQ_STATUS);
   assign wr_mask = i_wr && (i_addr == `TPB_ADDR_IRQ_MASK);

   // Count write takes the reload high bits plus the written byte
   assign write_value = {high_bits_q[`TPB_HB_RELOAD_HI:`TPB_HB_RELOAD_LO], i_wdata};

   // Duty is two high bits over the low duty byte
   assign duty_value = {high_bits_q[`TPB_HB_DUTY_HI:`TPB_HB_DUTY_LO], duty_low_q};

   // Control register writes
   // Reserved bits are masked off on the way in, so a read
   // shows zero there whatever software wrote, except bits 7:6 of
   // timer_high_bits, which read back the live top count bits
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl_one_q <= `TPB_RST_CTRL_ONE;
         ctrl_two_q <= `TPB_RST_CTRL_TWO;
         duty_low_q <= `TPB_RST_BYTE;
         buzzer_ctrl_q <= `TPB_RST_BUZZER;
         high_bits_q <= `TPB_RST_BYTE;
         hosc_sel_q <= 1'b0;
         irq_mask_q <= '0;
      end else begin
         // Unused bit positions stay zero
         if (wr_ctrl_one) begin
            ctrl_one_q <= i_wdata & `TPB_C1_RW_MASK;
         end
         // Rate may change at any time; a glitch is software's concern
         if (wr_ctrl_two) begin
            ctrl_two_q <= i_wdata & `TPB_C2_RW_MASK;
         end
         if (wr_duty) begin
            duty_low_q <= i_wdata;
         end
         if (wr_buzzer) begin
            buzzer_ctrl_q <= i_wdata & `TPB_BZ_RW_MASK;
         end
         if (wr_high) begin
            high_bits_q <= i_wdata & `TPB_HB_RW_MASK;
         end
         if (wr_hosc) begin
            hosc_sel_q <= i_wdata[`TPB_HOSC_SEL_BIT];
         end
         if (wr_mask) begin
            irq_mask_q <= i_wdata[`TPB_IRQ_BITS-1:0];
         end
      end
   end

   // External clock pin synchroniser
   // Two stages guard against a metastable pin level; the third
   // flop only keeps history for the edge detector, so an edge
   // is seen two clocks after it happens on the pin
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ext_meta_q <= 1'b0;
         ext_sync_q <= 1'b0;
         ext_prev_q <= 1'b0;
      end else begin
         ext_meta_q <= i_external_clock_pin;
         ext_sync_q <= ext_meta_q;
         ext_prev_q <= ext_sync_q;
      end
   end

   // Edge picked by the edge bit: 1 falling, 0 rising
   assign ext_edge = external_edge_select ? (ext_prev_q && !ext_sync_q)
                                          : (!ext_prev_q && ext_sync_q);

   // Source choice; the shared oscillator bit wins over the local one
   // Only one source is live at a time, so switching sources can
   // lose or add at most one tick around the switch
   always_comb begin
      if (hosc_sel_q) begin
         src_sel = TPB_SRC_HOSC;
      end else if (clock_source_select) begin
         src_sel = TPB_SRC_EXT;
      end else begin
         src_sel = TPB_SRC_INSTR;
      end
   end

   // Source tick from the one-hot selection
   always_comb begin
      case (src_sel)
         TPB_SRC_INSTR: src_tick = i_instr_tick;
         TPB_SRC_HOSC: src_tick = i_hosc_tick;
         TPB_SRC_EXT: src_tick = ext_edge;
         default: src_tick = 1'b0;
      endcase
   end

   // Mask of sel plus one low bits of the prescaler counter
   assign ps_mask = 8'((9'h002 << prescaler_rate_select) - 9'h001);

   // Limitation: a rate change while the prescaler is in use may
   // give one short or long period; software should bypass it
   // first and pick the rate then
   // Prescaler counter: free-running down counter on the source tick.
   // It keeps running when bypassed so the buzzer taps stay alive.
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ps_count_q <= `TPB_RST_PS_VALUE;
      end else if (src_tick) begin
         ps_count_q <= ps_count_q - 8'h01;
      end
   end

   // One timer tick per 2^(sel+1) source ticks, or every tick when bypassed
   // The tick fires where the low sel+1 bits are zero before the
   // decrement, so any run of 2^(sel+1) source ticks yields exactly one
   assign timer_tick = prescaler_disable_n ? src_tick
                                           : (src_tick && ((ps_count_q & ps_mask) == 8'h00));

   // Events of the timer
   // Non-stop underflow is the tick taken at zero; one-shot flags
   // the step from one to zero, since it never leaves zero after
   assign underflow = timer_enable && timer_tick && !one_shot_select && (count_q == `TPB_COUNT_ZERO);
   assign one_shot_done = timer_enable && timer_tick && one_shot_select && (count_q == `TPB_COUNT_ONE);

   // Timer count and reload register
   // Priority: software load first, then the tick; the reload
   // register changes only on a software load
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         count_q <= `TPB_COUNT_ALL_ONES;
         reload_q <= `TPB_COUNT_ALL_ONES;
      end else if (wr_count) begin
         // Software load wins over a tick in the same cycle
         count_q <= write_value;
         reload_q <= write_value;
      end else if (timer_enable && timer_tick) begin
         if (count_q != `TPB_COUNT_ZERO) begin
            count_q <= count_q - `TPB_COUNT_ONE;
         end else if (one_shot_select) begin
            count_q <= `TPB_COUNT_ZERO;
         end else if (reload_select) begin
            count_q <= reload_q;
         end else begin
            count_q <= `TPB_COUNT_ALL_ONES;
         end
      end
   end

   // Underflow toggle
   // It flips on every non-stop underflow whether or not the pin is
   // enabled, so enabling the pin later shows the true phase
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         toggle_q <= 1'b0;
      end else if (underflow) begin
         toggle_q <= !toggle_q;
      end
   end

   // Pin outputs: match toggle and its pin enable
   // Registered so every top-level output comes from a flop; this
   // costs one cycle of latency against the internal toggle
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_underflow_toggle_out <= 1'b0;
         o_match_output_enable <= 1'b0;
      end else begin
         // One cycle behind the internal toggle
         o_underflow_toggle_out <= toggle_q;
         o_match_output_enable <= match_output_enable;
      end
   end

   // PWM waveform; frame restarts as the count reloads
   // The compare uses the live duty value, so a new duty takes
   // effect at once rather than at the next frame; simpler, but a
   // duty change mid-frame may give one odd pulse width
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pwm_level <= 1'b0;
         o_pwm_output_enable <= 1'b0;
      end else begin
         // Active while below duty, then flipped for active low
         o_pwm_level <= (count_q < duty_value) ^ pwm_active_low;
         // When low, the pins go back to general-purpose use
         o_pwm_output_enable <= pwm_output_enable;
      end
   end

   // Buzzer: prescaler bit k or timer bit k, low when disabled
   // The prescaler taps keep moving while the prescaler is bypassed,
   // so the buzzer works without slowing the timer
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_buzzer <= 1'b0;
      end else if (!buzzer_enable) begin
         o_buzzer <= 1'b0;
      end else if (buzzer_frequency_select[`TPB_BZ_SRC_TIMER]) begin
         o_buzzer <= count_q[buzzer_frequency_select[`TPB_BZ_TAP_HI:0]];
      end else begin
         o_buzzer <= ps_count_q[buzzer_frequency_select[`TPB_BZ_TAP_HI:0]];
      end
   end

   // Sticky status; a new event beats a clear in the same cycle
   // Writing one clears a bit; written zeros leave it alone
   assign irq_events = {one_shot_done, underflow};
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         irq_status_q <= '0;
      end else begin
         irq_status_q <= (irq_status_q & ~(wr_status ? i_wdata[`TPB_IRQ_BITS-1:0] : '0)) | irq_events;
      end
   end

   // Level interrupt from any unmasked status bit
   // One cycle behind the status so the pin comes from a flop
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // Read mux; write-only and unmapped offsets read zero
   // The high-bits place shows the live top count bits in its
   // otherwise unused upper field
   always_comb begin
      rdata_d = 8'h00;
      case (i_addr)
         `TPB_ADDR_COUNT_LOW: rdata_d = count_q[7:0];
         `TPB_ADDR_CTRL_ONE: rdata_d = ctrl_one_q;
         `TPB_ADDR_CTRL_TWO: rdata_d = ctrl_two_q;
         `TPB_ADDR_PS_VALUE: rdata_d = ps_count_q;
         `TPB_ADDR_HIGH_BITS: rdata_d = {count_q[9:8], high_bits_q[5:0]};
         `TPB_ADDR_HOSC_SEL: rdata_d = {7'h00, hosc_sel_q};
         `TPB_ADDR_IRQ_STATUS: rdata_d = {6'h00, irq_status_q};
         `TPB_ADDR_IRQ_MASK: rdata_d = {6'h00, irq_mask_q};
         default: rdata_d = 8'h00;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   // Zero between reads keeps the bus quiet for an or-ed read fabric
   always_ff @(posedge i_clock or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= 8'h00;
      end else if (i_rd) begin
         o_rdata <= rdata_d;
      end else begin
         o_rdata <= 8'h00;
      end
   end

endmodule

`default_nettype wire

// >>> dv/tb.sv
/* Self-checking bench for the timer, PWM and buzzer unit.
   Assumes the bench drives every port itself; no far-side model. */
`timescale 1ns/100ps
`default_nettype none
module tb;
   logic i_clock = 1'b0, i_sys_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0; // Clock, reset, strobes
   logic i_instr_tick = 1'b0, i_hosc_tick = 1'b0, i_external_clock_pin = 1'b0; // Tick sources
   logic [3:0] i_addr = 4'h0;
   logic [7:0] i_wdata = 8'h00, o_rdata, p; // p holds a prescaler snapshot
   logic o_pwm_level, o_pwm_output_enable, o_underflow_toggle_out, o_match_output_enable, o_buzzer, o_irq;
   logic t0; // Toggle level before an underflow
   int n_fail = 0, comparisons = 0, cyc = 0;
   tpb_unit i_tpb_unit (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_instr_tick(i_instr_tick), .i_hosc_tick(i_hosc_tick),
      .i_external_clock_pin(i_external_clock_pin), .o_rdata(o_rdata), .o_pwm_level(o_pwm_level),
      .o_pwm_output_enable(o_pwm_output_enable), .o_underflow_toggle_out(o_underflow_toggle_out),
      .o_match_output_enable(o_match_output_enable), .o_buzzer(o_buzzer), .o_irq(o_irq));
   // 100 MHz clock
   always #5 i_clock = ~i_clock;
   // Hang guard, well above the 1400 or so cycles needed
   always @(posedge i_clock) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         test_done();
      end
   end
   task automatic test_done();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask
   // Wait edges, then step past them so outputs have settled
   task automatic w(input int n);
      repeat (n) @(posedge i_clock);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_clock);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clock);
      i_wr <= 1'b0;
   endtask
   task automatic get(input logic [3:0] a, output logic [7:0] g);
      @(posedge i_clock);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 g = o_rdata;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] g;
      get(a, g);
      chk($sformatf("reg %h", a), e, g);
   endtask
   // Write, then read the same place back with no gap
   task automatic wrd(input logic [3:0] a, input logic [7:0] d, input logic [7:0] e);
      wr(a, d);
      i_rd <= 1'b1;
      @(posedge i_clock);
      i_rd <= 1'b0;
      #1 chk($sformatf("reg %h", a), e, o_rdata);
   endtask
   // One-cycle ticks, every other cycle; h picks the high oscillator
   task automatic tk(input int n, input logic h);
      repeat (n) begin
         @(posedge i_clock);
         i_instr_tick <= !h;
         i_hosc_tick <= h;
         @(posedge i_clock);
         i_instr_tick <= 1'b0;
         i_hosc_tick <= 1'b0;
      end
   endtask
   // Slow pin pulses, long enough for the synchroniser
   task automatic pulses(input int n);
      repeat (n) begin
         @(posedge i_clock);
         i_external_clock_pin <= 1'b1;
         repeat (5) @(posedge i_clock);
         i_external_clock_pin <= 1'b0;
         repeat (5) @(posedge i_clock);
      end
   endtask
   task automatic t_regs();
      rd(4'h1, 8'h00);
      rd(4'h2, 8'h3F);
      rd(4'h0, 8'hFF);
      rd(4'h8, 8'hC0);
      rd(4'h3, 8'h00);
      rd(4'h5, 8'h00);
      wr(4'h4, 8'h12);
      rd(4'h4, 8'hFF);
      rd(4'hC, 8'h00);
      wr(4'h8, 8'hFE);
      wrd(4'h0, 8'h44, 8'h44);
      rd(4'h8, 8'hF2);
      wr(4'h8, 8'h00);
   endtask
   task automatic t_count();
      wr(4'h2, 8'h08);
      wr(4'hB, 8'h01);
      wrd(4'h0, 8'h03, 8'h03);
      wrd(4'h1, 8'h01, 8'h01);
      t0 = o_underflow_toggle_out;
      tk(3, 1'b0);
      rd(4'h0, 8'h00);
      tk(1, 1'b0);
      rd(4'h0, 8'hFF);
      rd(4'h8, 8'hC0);
      chk("toggle", 8'(!t0), 8'(o_underflow_toggle_out));
      chk("irq", 8'h01, 8'(o_irq));
      rd(4'hA, 8'h01);
      wr(4'hA, 8'h03);
      w(2);
      chk("irq", 8'h00, 8'(o_irq));
      wrd(4'h0, 8'h02, 8'h02);
      wrd(4'h1, 8'h03, 8'h03);
      tk(3, 1'b0);
      rd(4'h0, 8'h02);
      wr(4'hA, 8'h03);
      wrd(4'h1, 8'h07, 8'h07);
      wrd(4'h0, 8'h01, 8'h01);
      tk(3, 1'b0);
      rd(4'h0, 8'h00);
      rd(4'hA, 8'h02);
      wrd(4'h0, 8'h05, 8'h05);
      wrd(4'h1, 8'h20, 8'h20);
      tk(2, 1'b0);
      rd(4'h0, 8'h05);
      chk("match oe", 8'h01, 8'(o_match_output_enable));
   endtask
   // Every rate: one count step per divided period
   task automatic t_ps();
      logic [7:0] n;
      wrd(4'h1, 8'h01, 8'h01);
      for (int r = 0; r < 8; r++) begin
         n = 8'(2 << r);
         wr(4'h2, 8'(8'h08 | r));
         wr(4'h2, 8'(r));
         wrd(4'h0, 8'h80, 8'h80);
         get(4'h4, p);
         tk(2 << r, 1'b0);
         rd(4'h0, 8'h7F);
         rd(4'h4, p - n);
         wr(4'h2, 8'(8'h08 | r));
      end
   endtask
   task automatic t_ext();
      wr(4'h2, 8'h28);
      wrd(4'h0, 8'h10, 8'h10);
      pulses(2);
      tk(2, 1'b0);
      rd(4'h0, 8'h0E);
      wr(4'h2, 8'h38);
      pulses(2);
      rd(4'h0, 8'h0C);
      wr(4'h9, 8'h01);
      tk(3, 1'b1);
      rd(4'h0, 8'h09);
      wr(4'h9, 8'h00);
   endtask
   task automatic t_pwm();
      wr(4'h2, 8'h08);
      wr(4'h8, 8'h00);
      wr(4'h3, 8'h05);
      wrd(4'h0, 8'h0A, 8'h0A);
      wrd(4'h1, 8'hC3, 8'hC3);
      w(2);
      chk("pwm oe", 8'h01, 8'(o_pwm_output_enable));
      chk("pwm", 8'h01, 8'(o_pwm_level));
      tk(6, 1'b0);
      w(1);
      chk("pwm", 8'h00, 8'(o_pwm_level));
      tk(5, 1'b0);
      w(1);
      chk("pwm", 8'h01, 8'(o_pwm_level));
      wrd(4'h1, 8'h03, 8'h03);
      w(2);
      chk("pwm", 8'h00, 8'(o_pwm_level));
      chk("pwm oe", 8'h00, 8'(o_pwm_output_enable));
   endtask
   // All sixteen taps against a frozen prescaler and count
   task automatic t_buzz();
      logic [7:0] b;
      wrd(4'h1, 8'h00, 8'h00);
      wrd(4'h0, 8'hA5, 8'hA5);
      get(4'h4, p);
      for (int s = 0; s < 16; s++) begin
         b = (s < 8) ? p : 8'hA5;
         wr(4'h5, 8'(8'h80 | s));
         w(2);
         chk("buzzer", 8'(b[s % 8]), 8'(o_buzzer));
      end
      wr(4'h5, 8'h0F);
      w(2);
      chk("buzzer", 8'h00, 8'(o_buzzer));
   endtask
   initial begin
      repeat (5) @(posedge i_clock);
      i_sys_rst <= 1'b0;
      t_regs();
      t_count();
      t_ps();
      t_ext();
      t_pwm();
      t_buzz();
      test_done();
   end
endmodule
`default_nettype wire

// >>> dv/tpb_unit_checker.sv
/* Port assertions for the timer, PWM and buzzer unit.
   Assumes the unit's ports only; bound below to every instance. */
`timescale 1ns/100ps
`default_nettype none
module tpb_unit_checker #(
   parameter int COUNT_WIDTH = 10,
   parameter int PS_WIDTH = 8
) (
   input wire logic i_clock,
   input wire logic i_sys_rst,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic i_instr_tick,
   input wire logic i_hosc_tick,
   input wire logic i_external_clock_pin,
   input wire logic [7:0] o_rdata,
   input wire logic o_pwm_output_enable,
   input wire logic o_match_output_enable,
   input wire logic o_underflow_toggle_out,
   input wire logic o_buzzer
);
   // One clock domain: clock and reset given once
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_sys_rst);
   logic wr_c1; // Write to timer_control_one
   logic wr_bz; // Write to buzzer_control
   assign wr_c1 = i_wr && i_addr == 4'h1;
   assign wr_bz = i_wr && i_addr == 4'h5;
   // Read data may only show in the cycle after a read
   rdata_idle_a: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
      else $error("read data without a read");
   // Write-only places read back as zero
   wo_read_a: assert property (i_rd && (i_addr == 4'h3 || i_addr == 4'h5) |=> o_rdata == 8'h00)
      else $error("write-only place read nonzero");
   // A count write is what the next read returns, ticks or not
   count_load_a: assert property (i_wr && i_addr == 4'h0 ##1 i_rd && i_addr == 4'h0 |=>
      o_rdata == $past(i_wdata, 2)) else $error("count write not loaded");
   // Control bits read back as written, reserved bits zero
   ctrl_echo_a: assert property (wr_c1 ##1 i_rd && i_addr == 4'h1 |=>
      o_rdata == ($past(i_wdata, 2) & 8'hE7)) else $error("control readback wrong");
   // Pin ownership follows the written enable bits
   pwm_oe_a: assert property (wr_c1 ##1 !wr_c1 |=> o_pwm_output_enable == $past(i_wdata[7], 2))
      else $error("pwm pin enable wrong");
   match_oe_a: assert property (wr_c1 ##1 !wr_c1 |=> o_match_output_enable == $past(i_wdata[5], 2))
      else $error("match pin enable wrong");
   // A disabled buzzer stays low
   buzzer_off_a: assert property (wr_bz && !i_wdata[7] ##1 !wr_bz |=> !o_buzzer)
      else $error("buzzer active while disabled");
   // Without any tick no underflow can toggle the match output
   toggle_quiet_a: assert property ((!i_instr_tick && !i_hosc_tick && $stable(i_external_clock_pin)) [*6]
      |=> $stable(o_underflow_toggle_out)) else $error("toggle moved without a tick");
endmodule
bind tpb_unit tpb_unit_checker #(.COUNT_WIDTH(COUNT_WIDTH), .PS_WIDTH(PS_WIDTH)) i_chk (.i_clock(i_clock),
   .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
   .i_instr_tick(i_instr_tick), .i_hosc_tick(i_hosc_tick), .i_external_clock_pin(i_external_clock_pin),
   .o_rdata(o_rdata), .o_pwm_output_enable(o_pwm_output_enable), .o_buzzer(o_buzzer),
   .o_match_output_enable(o_match_output_enable), .o_underflow_toggle_out(o_underflow_toggle_out));
`default_nettype wire
